// ---- host_port_pkg.sv ----
package host_port_pkg;
    localparam int CLK_PERIOD_NS = 100;
    // recovery figure in tenths of a clock period (3 1/2 worst case)
    localparam int RECOVERY_TENTHS = 35;
    localparam int RECOVERY_CYCLES = (RECOVERY_TENTHS + 9) / 10;
    localparam logic [7:0] VECTOR_RESET = 8'h00;
    localparam logic [7:0] DATA_IDLE = 8'h00;
    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001,
        HS_STROBE = 4'b0010,
        HS_HOLD = 4'b0100,
        HS_RECOVER = 4'b1000
    } host_state_t;
endpackage

// ---- host_port_if.sv ----
`timescale 1ns/10ps
interface host_port_if;
    logic channelSelect;
    logic chipSelectN;
    logic dataControlSelect;
    logic readStrobeN;
    logic writeStrobeN;
    logic intAcknowledgeN;
    logic [7:0] hostData;
    logic [7:0] devData;
    logic devDataOe;
    logic intRequestNOut;
    logic intRequestNOe;
    logic intEnableIn;
    logic intEnableOut;
    modport device (
        input channelSelect, chipSelectN, dataControlSelect, readStrobeN, writeStrobeN,
        input intAcknowledgeN, hostData, intEnableIn,
        output devData, devDataOe, intRequestNOut, intRequestNOe, intEnableOut
    );
    modport host (
        output channelSelect, chipSelectN, dataControlSelect, readStrobeN, writeStrobeN,
        output intAcknowledgeN, hostData, intEnableIn,
        input devData, devDataOe, intRequestNOut, intRequestNOe, intEnableOut
    );
endinterface

// ---- device_port.sv ----
`timescale 1ns/10ps
module device_port (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // bus side
    host_port_if.device bus,
    // core side
    input wire logic [7:0] readValue,
    input wire logic [7:0] intVector,
    input wire logic intPending,
    input wire logic intServiceDone,
    output logic writeStrobe,
    output logic readStrobe,
    output logic [7:0] writeData,
    output logic accessChannelA,
    output logic accessData,
    output logic softReset,
    output logic underService
);
    // ==========================================================
    // input synchronisers (3 stages, act when stages 2 and 3 agree)
    logic [3:0] pinRaw;
    logic [3:0] pinSync;
    logic csN;
    logic rdN;
    logic wrN;
    logic ackN;

    assign pinRaw = {bus.intAcknowledgeN, bus.writeStrobeN, bus.readStrobeN, bus.chipSelectN};

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            logic [2:0] stage_reg, stage_next;
            logic level_reg, level_next;

            always_comb begin
                stage_next = {stage_reg[1:0], pinRaw[g]};
                // a lone glitch in stage 2 never reaches the decode
                level_next = (stage_reg[1] == stage_reg[2]) ? stage_reg[2] : level_reg;
            end

            always_ff @(posedge mclk or negedge resetn) begin
                if (!resetn) begin
                    stage_reg <= 3'h7;
                    level_reg <= 1'b1;
                end else begin
                    stage_reg <= stage_next;
                    level_reg <= level_next;
                end
            end

            assign pinSync[g] = level_reg;
        end
    endgenerate

    assign csN = pinSync[0];
    assign rdN = pinSync[1];
    assign wrN = pinSync[2];
    assign ackN = pinSync[3];

    // ==========================================================
    // access decode and core strobes
    logic both;
    logic ackCycle;
    logic rdAct;
    logic wrAct;
    logic rdOld_reg, rdOld_next;
    logic wrOld_reg, wrOld_next;
    logic bothOld_reg, bothOld_next;
    logic rstb_reg, rstb_next;
    logic wstb_reg, wstb_next;
    logic rst_reg, rst_next;
    logic [7:0] wdata_reg, wdata_next;
    logic chA_reg, chA_next;
    logic dat_reg, dat_next;

    always_comb begin
        both = !rdN && !wrN;
        ackCycle = !ackN;
        // strobes count only while selected and outside an acknowledge cycle
        rdAct = !rdN && !both && !csN && !ackCycle;
        wrAct = !wrN && !both && !csN && !ackCycle;
        rdOld_next = rdAct;
        wrOld_next = wrAct;
        bothOld_next = both;
        rst_next = both && !bothOld_reg;
        rstb_next = rdAct && !rdOld_reg;
        // write taken at strobe release, so data that settles late still lands
        wstb_next = !wrAct && wrOld_reg;
        wdata_next = wrAct ? bus.hostData : wdata_reg;
        chA_next = (rdAct || wrAct) ? bus.channelSelect : chA_reg;
        dat_next = (rdAct || wrAct) ? bus.dataControlSelect : dat_reg;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdOld_reg <= 1'b0;
            wrOld_reg <= 1'b0;
            bothOld_reg <= 1'b0;
            rstb_reg <= 1'b0;
            wstb_reg <= 1'b0;
            rst_reg <= 1'b0;
            wdata_reg <= 8'h00;
            chA_reg <= 1'b0;
            dat_reg <= 1'b0;
        end else begin
            rdOld_reg <= rdOld_next;
            wrOld_reg <= wrOld_next;
            bothOld_reg <= bothOld_next;
            rstb_reg <= rstb_next;
            wstb_reg <= wstb_next;
            rst_reg <= rst_next;
            wdata_reg <= wdata_next;
            chA_reg <= chA_next;
            dat_reg <= dat_next;
        end
    end

    // ==========================================================
    // interrupt daisy chain
    logic winner;
    logic vecRd;
    logic vecHold_reg, vecHold_next;
    logic ius_reg, ius_next;
    logic ieo_reg, ieo_next;
    logic irq_reg, irq_next;

    always_comb begin
        // highest-priority requester: chain clear above and own request up
        winner = ackCycle && bus.intEnableIn && intPending && !ius_reg;
        // once won, the vector stays on the bus until the read strobe ends
        vecRd = ackCycle && !rdN && wrN && (winner || vecHold_reg);
        vecHold_next = vecRd;
        ius_next = ius_reg;
        if (vecRd) begin
            ius_next = 1'b1;
        end else if (intServiceDone || rst_next) begin
            ius_next = 1'b0;
        end
        ieo_next = bus.intEnableIn && !ius_reg && !(intPending && ackCycle);
        irq_next = !(intPending && !ius_reg);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            vecHold_reg <= 1'b0;
            ius_reg <= 1'b0;
            ieo_reg <= 1'b0;
            irq_reg <= 1'b1;
        end else begin
            vecHold_reg <= vecHold_next;
            ius_reg <= ius_next;
            ieo_reg <= ieo_next;
            irq_reg <= irq_next;
        end
    end

    // ==========================================================
    // data line drive
    logic oe_reg, oe_next;
    logic [7:0] dout_reg, dout_next;

    always_comb begin
        oe_next = rdAct || vecRd;
        dout_next = host_port_pkg::DATA_IDLE;
        if (rdAct) begin
            dout_next = readValue;
        end else if (vecRd) begin
            dout_next = intVector;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            oe_reg <= 1'b0;
            dout_reg <= host_port_pkg::DATA_IDLE;
        end else begin
            oe_reg <= oe_next;
            dout_reg <= dout_next;
        end
    end

    // ==========================================================
    // outputs
    assign bus.devData = dout_reg;
    assign bus.devDataOe = oe_reg;
    assign bus.intEnableOut = ieo_reg;
    assign bus.intRequestNOut = 1'b0;
    assign bus.intRequestNOe = !irq_reg;
    assign writeStrobe = wstb_reg;
    assign readStrobe = rstb_reg;
    assign writeData = wdata_reg;
    assign accessChannelA = chA_reg;
    assign accessData = dat_reg;
    assign softReset = rst_reg;
    assign underService = ius_reg;
endmodule

// ---- host_port.sv ----
`timescale 1ns/10ps
module host_port (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // bus side
    host_port_if.host bus,
    // user side
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic reqAck,
    input wire logic reqReset,
    input wire logic reqChannelA,
    input wire logic reqData,
    input wire logic [7:0] reqWdata,
    input wire logic chainEnable,
    output logic busy,
    output logic doneValid,
    output logic [7:0] doneRdata,
    output logic intSeen
);
    localparam int HOLD_CYCLES = 8;
    localparam int REC_CYCLES = host_port_pkg::RECOVERY_CYCLES + 4;
    host_port_pkg::host_state_t st_reg, st_next;
    logic [3:0] cnt_reg, cnt_next;
    logic cs_reg, cs_next, rd_reg, rd_next, wr_reg, wr_next, ack_reg, ack_next;
    logic chA_reg, chA_next, dc_reg, dc_next, wrq_reg, wrq_next;
    logic [7:0] wd_reg, wd_next, rdat_reg, rdat_next;
    logic done_reg, done_next, int_reg, int_next, iei_reg, iei_next;
    logic busy_reg, busy_next;
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        cs_next = cs_reg;
        rd_next = rd_reg;
        wr_next = wr_reg;
        ack_next = ack_reg;
        chA_next = chA_reg;
        dc_next = dc_reg;
        wrq_next = wrq_reg;
        wd_next = wd_reg;
        rdat_next = rdat_reg;
        done_next = 1'b0;
        // open-drain line: low only while the far end enables its low drive
        int_next = bus.intRequestNOe && !bus.intRequestNOut;
        iei_next = chainEnable;
        case (st_reg)
            host_port_pkg::HS_IDLE: begin
                if (reqValid) begin
                    // select set up before the strobe; a reset request drops both strobes in the same cycle
                    cs_next = reqAck;
                    ack_next = !reqAck;
                    chA_next = reqChannelA;
                    dc_next = reqData;
                    wd_next = reqWdata;
                    wrq_next = reqWrite;
                    cnt_next = 4'h2;
                    st_next = host_port_pkg::HS_STROBE;
                    if (reqReset) begin
                        rd_next = 1'b0;
                        wr_next = 1'b0;
                    end
                end
            end
            host_port_pkg::HS_STROBE: begin
                if (cnt_reg == 4'h0) begin
                    if (rd_reg) begin
                        rd_next = wrq_reg;
                        wr_next = !wrq_reg;
                    end
                    cnt_next = 4'(HOLD_CYCLES);
                    st_next = host_port_pkg::HS_HOLD;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            host_port_pkg::HS_HOLD: begin
                if (cnt_reg == 4'h0) begin
                    rdat_next = bus.devData;
                    done_next = 1'b1;
                    rd_next = 1'b1;
                    wr_next = 1'b1;
                    cnt_next = 4'(REC_CYCLES);
                    st_next = host_port_pkg::HS_RECOVER;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            host_port_pkg::HS_RECOVER: begin
                cs_next = 1'b1;
                ack_next = 1'b1;
                if (cnt_reg == 4'h0) begin
                    st_next = host_port_pkg::HS_IDLE;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            default: begin
                st_next = host_port_pkg::HS_IDLE;
            end
        endcase
        busy_next = (st_next != host_port_pkg::HS_IDLE);
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= host_port_pkg::HS_IDLE;
            cnt_reg <= 4'h0;
            cs_reg <= 1'b1;
            rd_reg <= 1'b1;
            wr_reg <= 1'b1;
            ack_reg <= 1'b1;
            chA_reg <= 1'b0;
            dc_reg <= 1'b0;
            wrq_reg <= 1'b0;
            wd_reg <= 8'h00;
            rdat_reg <= 8'h00;
            done_reg <= 1'b0;
            int_reg <= 1'b0;
            iei_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            cs_reg <= cs_next;
            rd_reg <= rd_next;
            wr_reg <= wr_next;
            ack_reg <= ack_next;
            chA_reg <= chA_next;
            dc_reg <= dc_next;
            wrq_reg <= wrq_next;
            wd_reg <= wd_next;
            rdat_reg <= rdat_next;
            done_reg <= done_next;
            int_reg <= int_next;
            iei_reg <= iei_next;
            busy_reg <= busy_next;
        end
    end
    assign bus.chipSelectN = cs_reg;
    assign bus.readStrobeN = rd_reg;
    assign bus.writeStrobeN = wr_reg;
    assign bus.intAcknowledgeN = ack_reg;
    assign bus.channelSelect = chA_reg;
    assign bus.dataControlSelect = dc_reg;
    assign bus.hostData = wd_reg;
    assign bus.intEnableIn = iei_reg;
    assign busy = busy_reg;
    assign doneValid = done_reg;
    assign doneRdata = rdat_reg;
    assign intSeen = int_reg;
endmodule

// ---- host_port_asserts.sv ----
`timescale 1ns/10ps
// ==========
// interface checks beside the host port interface
module host_port_asserts (
    // clock and reset
    input logic mclk,
    input logic resetn,
    // bus signals
    input logic chipSelectN,
    input logic readStrobeN,
    input logic writeStrobeN,
    input logic intAcknowledgeN,
    input logic devDataOe,
    input logic intRequestNOut,
    input logic intRequestNOe,
    input logic intEnableIn,
    input logic intEnableOut
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    a_oe_needs_read: assert property ($rose(devDataOe) |-> !readStrobeN)
        else $error("data drive began without read strobe");
    a_read_drives_bus: assert property (
        $fell(readStrobeN) && writeStrobeN && !chipSelectN && intAcknowledgeN
        |-> ##[2:8] devDataOe)
        else $error("selected read did not drive the bus");
    a_vector_on_ack: assert property (
        $fell(readStrobeN) && !intAcknowledgeN && intEnableIn && intRequestNOe
        |-> ##[2:8] devDataOe)
        else $error("vector not driven in acknowledge");
    a_drive_stands: assert property ($rose(devDataOe) |-> devDataOe[*6])
        else $error("data drive dropped before the host could sample it");
    a_vector_blocked: assert property ((!intAcknowledgeN && !intEnableIn)[*6] |-> !devDataOe)
        else $error("vector driven with chain blocked");
    a_reset_no_access: assert property ($fell(readStrobeN) && !writeStrobeN |-> !devDataOe[*8])
        else $error("read and write together drove the bus");
    a_idle_release: assert property ((chipSelectN && intAcknowledgeN)[*8] |-> !devDataOe)
        else $error("bus driven while not selected");
    a_chain_blocked: assert property (!intEnableIn[*6] |-> !intEnableOut)
        else $error("enable out high with enable in low");
    a_pend_blocks: assert property ((!intAcknowledgeN && intRequestNOe)[*6] |-> !intEnableOut)
        else $error("enable out high while requesting in acknowledge");
    a_irq_low: assert property (intRequestNOe |-> !intRequestNOut)
        else $error("request line enabled but not low");
endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
// ==========
// bench for both ends of the host port
module tb_top;
    logic mclk, resetn, reqValid, reqWrite, reqAck, reqReset, reqChannelA, reqData, chainEnable;
    logic [7:0] reqWdata, readValue, intVector, doneRdata, writeData, d;
    logic intPending, intServiceDone, busy, doneValid, intSeen, writeStrobe, readStrobe;
    logic accessChannelA, accessData, softReset, underService;
    logic [2:0] k;
    int bad_count, samples_checked, nStrobe, nSoft, e;
    int qDone[$];
    int qDev[$];
    host_port_if bus();
    host_port i_host_port(.mclk, .resetn, .bus(bus), .reqValid, .reqWrite, .reqAck, .reqReset,
        .reqChannelA, .reqData, .reqWdata, .chainEnable, .busy, .doneValid, .doneRdata, .intSeen);
    device_port i_device_port(.mclk, .resetn, .bus(bus), .readValue, .intVector, .intPending,
        .intServiceDone, .writeStrobe, .readStrobe, .writeData, .accessChannelA, .accessData,
        .softReset, .underService);
    host_port_asserts i_host_port_asserts(.mclk, .resetn, .chipSelectN(bus.chipSelectN),
        .readStrobeN(bus.readStrobeN), .writeStrobeN(bus.writeStrobeN),
        .intAcknowledgeN(bus.intAcknowledgeN), .devDataOe(bus.devDataOe),
        .intRequestNOut(bus.intRequestNOut), .intRequestNOe(bus.intRequestNOe),
        .intEnableIn(bus.intEnableIn), .intEnableOut(bus.intEnableOut));
    task automatic check(input logic ok, input string what);
        samples_checked++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("MISMATCH at %0t: %s", $time, what);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // one transfer, then wait for the host to finish its recovery
    task automatic req(input logic w, a, r, ch, dc, input logic [7:0] wd);
        int n;
        @(posedge mclk) #1;
        {reqWrite, reqAck, reqReset, reqChannelA, reqData, reqWdata} = {w, a, r, ch, dc, wd};
        reqValid = 1'b1;
        wait_cycles(1);
        reqValid = 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            wait_cycles(1);
            n++;
        end
        if (n == 200) begin
            check(1'b0, "host stuck");
            test_done();
        end
    endtask
    // ==========
    // result monitor against the queued model
    always @(posedge mclk) begin
        if (doneValid === 1'b1 && qDone.size() > 0) begin
            if (qDone[0] >= 0) check(doneRdata === 8'(qDone[0]), "read data");
            void'(qDone.pop_front());
        end
        if (readStrobe === 1'b1 || writeStrobe === 1'b1) begin
            nStrobe++;
            if (qDev.size() > 0) begin
                e = qDev.pop_front();
                check({writeStrobe, accessChannelA, accessData} === 3'(e >> 8), "kind");
                if (e[10]) check(writeData === 8'(e), "write data");
            end
        end
        if (softReset === 1'b1) nSoft++;
    end
    initial begin
        mclk = 1'b0;
        forever #(host_port_pkg::CLK_PERIOD_NS / 2) mclk = ~mclk;
    end
    // ==========
    // main sequence
    initial begin
        {reqValid, reqWrite, reqAck, reqReset, reqChannelA, reqData, chainEnable} = '0;
        {reqWdata, readValue, intVector, intPending, intServiceDone} = '0;
        resetn = 1'b0;
        void'($urandom(63640));
        wait_cycles(10);
        resetn = 1'b1;
        for (int i = 0; i < 12; i++) begin
            k = (i < 8) ? 3'(i) : 3'($urandom);
            d = 8'($urandom);
            readValue = 8'($urandom);
            qDev.push_back(int'({k[2], k[0], k[1], d}));
            qDone.push_back(k[2] ? -1 : int'(readValue));
            req(k[2], 1'b0, 1'b0, k[0], k[1], d);
        end
        check(nStrobe == 12, "access count");
        intVector = 8'($urandom);
        chainEnable = 1'b1;
        intPending = 1'b1;
        wait_cycles(10);
        check(bus.intRequestNOe === 1'b1 && bus.intRequestNOut === 1'b0, "request");
        check(intSeen === 1'b1, "request seen");
        qDone.push_back(int'(intVector));
        req(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
        wait_cycles(10);
        check(underService === 1'b1 && bus.intEnableOut === 1'b0, "in service");
        intPending = 1'b0;
        intServiceDone = 1'b1;
        wait_cycles(1);
        intServiceDone = 1'b0;
        wait_cycles(10);
        check(underService === 1'b0 && bus.intEnableOut === 1'b1, "chain open");
        check(intSeen === 1'b0, "request gone");
        chainEnable = 1'b0;
        intPending = 1'b1;
        qDone.push_back(-1);
        req(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
        wait_cycles(10);
        check(underService === 1'b0 && bus.intEnableOut === 1'b0, "chain shut");
        check(intSeen === 1'b1, "request again");
        intPending = 1'b0;
        qDone.push_back(-1);
        req(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
        wait_cycles(10);
        check(nSoft == 1 && nStrobe == 12, "reset pulse");
        test_done();
    end
endmodule
